/* File: hdl/aic_top.v */
// i2c register access and conversion sequencing for a four channel adc
// Function
// - non-channel registers take two data bytes
// - write: address, pointer, msb, lsb, all acked
// - further pointer and data pairs until stop
// - pointer kept across transactions
// - pointer-only write changes no register
// - read sends byte pairs until master nacks
// - reset: sample mode, channel 0 only
// - sample mode when cmd equals auto
// - start pin fall holds and converts 550 ns
// - sample pulses step mask from lowest channel
// - command mode when cmd set, auto clear
// - result read triggers next channel conversion
// - conversion starts on scl rise after ack
// - result bytes: channel, alert, msbs; then lsbs
// - converter powers down between command conversions
// - sequence wraps to lowest selected channel
// - nack stops; later read resumes next channel
// - channel write restarts sequence at lowest
// - pointer 0 result, 1 channel, 2 config
// - channel register one byte, bit per channel
// - slave address 010 plus two strap fields
`timescale 1ns/1ps
`include "aic_map.vh"
module aic_top (
    input wire sys_clk,
    input wire nrst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    input wire conversion_start_pin_n,
    input wire [1:0] address_strap_low,
    input wire [1:0] address_strap_high,
    input wire [11:0] adc_sample_data,
    input wire adc_alert,
    output wire adc_hold,
    output wire [1:0] adc_channel,
    output wire adc_power_down,
    output wire conv_busy
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RX = 3'h1;
    localparam [2:0] S_ACK = 3'h2;
    localparam [2:0] S_TX = 3'h3;
    localparam [2:0] S_MACK = 3'h4;
    localparam [2:0] S_IGN = 3'h5;
    localparam [1:0] W_PTR = 2'h0;
    localparam [1:0] W_MSB = 2'h1;
    localparam [1:0] W_LSB = 2'h2;
    localparam [1:0] C_IDLE = 2'h0;
    localparam [1:0] C_CONV = 2'h1;
    localparam [1:0] C_PUSH = 2'h2;
    localparam [31:0] CONV_LAST_W = `AIC_CONV_CYC - 1;
    localparam [4:0] CONV_LAST = CONV_LAST_W[4:0];

    wire [2:0] pin_s;
    wire [3:0] strap_s;
    wire scl_s;
    wire sda_s;
    wire cvs_s;
    reg scl_d_reg;
    reg sda_d_reg;
    reg cvs_d_reg;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire cvs_fall;

    reg [1:0] strap_cnt_reg;
    reg [6:0] slave_addr_reg;
    reg [1:0] strap_hi_bits;
    reg [1:0] strap_lo_bits;

    reg [2:0] st_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg first_reg;
    reg rd_reg;
    reg lo_reg;
    reg [1:0] wph_reg;
    reg [7:0] msb_hold_reg;
    reg [7:0] ptr_reg;
    reg sda_oe_n_reg;
    reg [7:0] chan_reg;
    reg [15:0] cfg_reg;
    reg [15:0] result_reg;
    reg chan_wr_reg;
    reg cmd_arm_reg;

    reg [1:0] cst_reg;
    reg [4:0] ccnt_reg;
    reg [1:0] conv_chan_reg;
    reg [1:0] seq_last_reg;
    reg seq_valid_reg;
    reg [15:0] conv_word_reg;

    wire sample_mode;
    wire cmd_mode;
    wire cmd_go;
    wire start_req;
    wire buf_in_ready;
    wire buf_out_valid;
    wire buf_out_ready;
    wire [15:0] buf_out_data;
    reg [1:0] next_chan;
    reg found_above;
    reg found_any;
    reg [1:0] chan_above;
    reg [1:0] chan_low;
    reg [15:0] tx_word;
    reg [1:0] live_chan;
    wire [7:0] tx_byte;
    wire [7:0] next_byte;
    integer i;

    aic_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_pin_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .d({scl_in, sda_in, conversion_start_pin_n}),
        .q(pin_s)
    );

    aic_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_strap_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .d({address_strap_high, address_strap_low}),
        .q(strap_s)
    );

    assign scl_s = pin_s[2];
    assign sda_s = pin_s[1];
    assign cvs_s = pin_s[0];
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign cvs_fall = cvs_d_reg & ~cvs_s;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            cvs_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            cvs_d_reg <= cvs_s;
        end
    end

    // three-level strap to two address bits: high 00, floating 10, low 11
    always @* begin
        case (strap_s[3:2])
            `AIC_STRAP_HIGH: strap_hi_bits = 2'h0;
            `AIC_STRAP_LOW: strap_hi_bits = 2'h3;
            default: strap_hi_bits = 2'h2;
        endcase
        case (strap_s[1:0])
            `AIC_STRAP_HIGH: strap_lo_bits = 2'h0;
            `AIC_STRAP_LOW: strap_lo_bits = 2'h3;
            default: strap_lo_bits = 2'h2;
        endcase
    end

    // straps are loaded on each of the first three clocks and held from the third, once the synchroniser has settled
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            strap_cnt_reg <= 2'h0;
            slave_addr_reg <= 7'h00;
        end else if (strap_cnt_reg != `AIC_STRAP_SETTLE) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            slave_addr_reg <= {`AIC_ADDR_FIXED, strap_hi_bits, strap_lo_bits};
        end
    end

    assign sample_mode = (cfg_reg[`AIC_CFG_CMD_BIT] == cfg_reg[`AIC_CFG_AUTO_BIT]);
    assign cmd_mode = cfg_reg[`AIC_CFG_CMD_BIT] & ~cfg_reg[`AIC_CFG_AUTO_BIT];
    assign cmd_go = cmd_arm_reg & scl_rise;

    // channel field follows the conversion being started in command mode
    always @* begin
        live_chan = result_reg[14:13];
        if (cmd_mode) begin
            live_chan = cmd_arm_reg ? next_chan : conv_chan_reg;
        end
        case (ptr_reg)
            `AIC_REG_RESULT: tx_word = {1'b0, live_chan, result_reg[12:0]};
            `AIC_REG_CHAN: tx_word = {8'h00, chan_reg};
            `AIC_REG_CFG: tx_word = cfg_reg;
            default: tx_word = 16'h0000;
        endcase
    end

    assign tx_byte = lo_reg ? tx_word[7:0] : tx_word[15:8];
    assign next_byte = lo_reg ? tx_word[15:8] : tx_word[7:0];

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= S_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            first_reg <= 1'b0;
            rd_reg <= 1'b0;
            lo_reg <= 1'b0;
            wph_reg <= W_PTR;
            msb_hold_reg <= 8'h00;
            ptr_reg <= `AIC_REG_RESULT;
            sda_oe_n_reg <= 1'b1;
            chan_reg <= `AIC_CHAN_RST;
            cfg_reg <= `AIC_CFG_RST;
            chan_wr_reg <= 1'b0;
            cmd_arm_reg <= 1'b0;
        end else begin
            chan_wr_reg <= 1'b0;
            if (cmd_go) begin
                cmd_arm_reg <= 1'b0;
            end
            if (start_det) begin
                st_reg <= S_RX;
                bit_cnt_reg <= 4'h0;
                first_reg <= 1'b1;
                sda_oe_n_reg <= 1'b1;
                cmd_arm_reg <= 1'b0;
            end else if (stop_det) begin
                st_reg <= S_IDLE;
                sda_oe_n_reg <= 1'b1;
                cmd_arm_reg <= 1'b0;
            end else begin
                case (st_reg)
                    S_RX: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            if (first_reg) begin
                                first_reg <= 1'b0;
                                if (shift_reg[7:1] == slave_addr_reg) begin
                                    rd_reg <= shift_reg[0];
                                    wph_reg <= W_PTR;
                                    lo_reg <= 1'b0;
                                    st_reg <= S_ACK;
                                    sda_oe_n_reg <= 1'b0;
                                end else begin
                                    st_reg <= S_IGN;
                                end
                            end else begin
                                st_reg <= S_ACK;
                                sda_oe_n_reg <= 1'b0;
                                case (wph_reg)
                                    W_PTR: begin
                                        ptr_reg <= shift_reg;
                                        wph_reg <= W_MSB;
                                    end
                                    W_MSB: begin
                                        if (ptr_reg == `AIC_REG_CHAN) begin
                                            chan_reg <= shift_reg;
                                            chan_wr_reg <= 1'b1;
                                            wph_reg <= W_PTR;
                                        end else begin
                                            msb_hold_reg <= shift_reg;
                                            wph_reg <= W_LSB;
                                        end
                                    end
                                    default: begin
                                        if (ptr_reg == `AIC_REG_CFG) begin
                                            cfg_reg <= {msb_hold_reg, shift_reg};
                                        end
                                        wph_reg <= W_PTR;
                                    end
                                endcase
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (rd_reg) begin
                                st_reg <= S_TX;
                                sda_oe_n_reg <= tx_byte[7];
                                if (cmd_mode && ptr_reg == `AIC_REG_RESULT) begin
                                    cmd_arm_reg <= 1'b1;
                                end
                            end else begin
                                st_reg <= S_RX;
                                sda_oe_n_reg <= 1'b1;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h7) begin
                                st_reg <= S_MACK;
                                sda_oe_n_reg <= 1'b1;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                sda_oe_n_reg <= tx_byte[3'h6 - bit_cnt_reg[2:0]];
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise && sda_s) begin
                            st_reg <= S_IGN;
                        end else if (scl_fall) begin
                            st_reg <= S_TX;
                            bit_cnt_reg <= 4'h0;
                            lo_reg <= ~lo_reg;
                            sda_oe_n_reg <= next_byte[7];
                            if (lo_reg && cmd_mode && ptr_reg == `AIC_REG_RESULT) begin
                                cmd_arm_reg <= 1'b1;
                            end
                        end
                    end
                    S_IGN: begin
                        sda_oe_n_reg <= 1'b1;
                    end
                    default: begin
                        st_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // next channel: lowest selected above the last one, else lowest selected
    always @* begin
        found_above = 1'b0;
        found_any = 1'b0;
        chan_above = 2'h0;
        chan_low = 2'h0;
        for (i = 3; i >= 0; i = i - 1) begin
            if (chan_reg[i]) begin
                chan_low = i[1:0];
                found_any = 1'b1;
                if (seq_valid_reg && i[1:0] > seq_last_reg) begin
                    chan_above = i[1:0];
                    found_above = 1'b1;
                end
            end
        end
        next_chan = found_above ? chan_above : chan_low;
        if (!found_any) begin
            next_chan = 2'h0;
        end
    end

    assign start_req = (sample_mode & cvs_fall) | (cmd_mode & cmd_go);

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cst_reg <= C_IDLE;
            ccnt_reg <= 5'h00;
            conv_chan_reg <= 2'h0;
            seq_last_reg <= 2'h0;
            seq_valid_reg <= 1'b0;
            conv_word_reg <= 16'h0000;
        end else begin
            case (cst_reg)
                C_IDLE: begin
                    if (start_req) begin
                        conv_chan_reg <= next_chan;
                        seq_last_reg <= next_chan;
                        seq_valid_reg <= 1'b1;
                        ccnt_reg <= 5'h00;
                        cst_reg <= C_CONV;
                    end
                end
                C_CONV: begin
                    if (ccnt_reg == CONV_LAST) begin
                        conv_word_reg <= {1'b0, conv_chan_reg, adc_alert, adc_sample_data};
                        cst_reg <= C_PUSH;
                    end else begin
                        ccnt_reg <= ccnt_reg + 5'h01;
                    end
                end
                C_PUSH: begin
                    if (buf_in_ready) begin
                        cst_reg <= C_IDLE;
                    end
                end
                default: begin
                    cst_reg <= C_IDLE;
                end
            endcase
            if (chan_wr_reg) begin
                seq_valid_reg <= 1'b0;
            end
        end
    end

    // result word is not replaced while its low byte is on the bus
    assign buf_out_ready = ~(st_reg == S_TX && lo_reg && ptr_reg == `AIC_REG_RESULT);

    aic_buf2 #(.WIDTH(16)) u_result_buf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(cst_reg == C_PUSH),
        .in_ready(buf_in_ready),
        .in_data(conv_word_reg),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            result_reg <= `AIC_RESULT_RST;
        end else if (buf_out_valid && buf_out_ready) begin
            result_reg <= buf_out_data;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = sda_oe_n_reg;
    assign adc_hold = (cst_reg == C_CONV);
    assign adc_channel = conv_chan_reg;
    assign adc_power_down = cmd_mode & (cst_reg != C_CONV);
    assign conv_busy = (cst_reg != C_IDLE);
endmodule // aic_top

/* File: hdl/aic_map.vh */
// register map, field positions, reset values and timing for the adc i2c control
`ifndef AIC_MAP_VH
`define AIC_MAP_VH

// register pointer values
`define AIC_REG_RESULT 8'h00
`define AIC_REG_CHAN 8'h01
`define AIC_REG_CFG 8'h02

// configuration fields and reset values
`define AIC_CFG_CMD_BIT 9
`define AIC_CFG_AUTO_BIT 8
`define AIC_CFG_RST 16'h0000
`define AIC_CHAN_RST 8'h01
`define AIC_RESULT_RST 16'h0000

// slave address: fixed upper bits, strap level codes
`define AIC_ADDR_FIXED 3'h2
`define AIC_STRAP_LOW 2'h0
`define AIC_STRAP_HIGH 2'h1
`define AIC_STRAP_FLOAT 2'h2
`define AIC_STRAP_SETTLE 2'h3

// conversion time in ns, clock period in ns, cycles rounded up
`define AIC_CONV_NS 550
`define AIC_CLK_NS 25
`define AIC_CONV_CYC ((`AIC_CONV_NS + `AIC_CLK_NS - 1) / `AIC_CLK_NS)

`endif

/* File: hdl/aic_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module aic_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire nrst,
    input wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // aic_sync

/* File: hdl/aic_buf2.v */
// two-entry valid/ready buffer
`timescale 1ns/1ps
module aic_buf2 #(
    parameter WIDTH = 16
) (
    input wire sys_clk,
    input wire nrst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg wr_ptr_reg;
    reg rd_ptr_reg;
    reg [1:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mem_reg[0] <= {WIDTH{1'b0}};
            mem_reg[1] <= {WIDTH{1'b0}};
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule // aic_buf2

/* File: sim/aic_properties.sv */
// assertion checker for the adc i2c control block
`timescale 1ns/1ps
`include "aic_map.vh"
module aic_properties (
    input wire sys_clk,
    input wire nrst,
    input wire scl_in,
    input wire sda_oe_n,
    input wire conversion_start_pin_n,
    input wire adc_hold,
    input wire [1:0] adc_channel,
    input wire adc_power_down,
    input wire conv_busy
);
    reg [7:0] hold_cnt_reg;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            hold_cnt_reg <= 8'h00;
        else
            hold_cnt_reg <= adc_hold ? hold_cnt_reg + 8'h01 : 8'h00;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_reset_state;
        $rose(nrst) |-> sda_oe_n && !adc_hold && adc_channel == 2'h0 && !conv_busy;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_conv_len;
        $fell(adc_hold) |-> hold_cnt_reg == `AIC_CONV_CYC;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_hold_busy;
        adc_hold |-> conv_busy;
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("hold without busy");
    property p_hold_pd;
        adc_hold |-> !adc_power_down;
    endproperty
    a_hold_pd: assert property (p_hold_pd) else $error("powered down while converting");
    property p_chan_stable;
        adc_hold && $past(adc_hold) |-> $stable(adc_channel);
    endproperty
    a_chan_stable: assert property (p_chan_stable) else $error("channel moved in hold");
    property p_conv_cause;
        $rose(adc_hold) |-> scl_in || !conversion_start_pin_n;
    endproperty
    a_conv_cause: assert property (p_conv_cause) else $error("conversion without cause");
    property p_oe_scl_low;
        $changed(sda_oe_n) |-> !scl_in;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
    property p_ack_hold;
        $fell(sda_oe_n) |-> !sda_oe_n [*6];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("driven bit too short");
endmodule // aic_properties
bind aic_top aic_properties u_props (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in),
    .sda_oe_n(sda_oe_n), .conversion_start_pin_n(conversion_start_pin_n),
    .adc_hold(adc_hold), .adc_channel(adc_channel), .adc_power_down(adc_power_down),
    .conv_busy(conv_busy));

/* File: sim/aic_i2c_master.sv */
// i2c bus master model for the block's serial link
`timescale 1ns/1ps
module aic_i2c_master (
    output reg scl,
    output reg sda_m,
    input wire sda
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task bus_start;
        #50 sda_m = 1'b1;
        #50 scl = 1'b1;
        #50 sda_m = 1'b0;
        #50 scl = 1'b0;
    endtask
    task bus_stop;
        #50 sda_m = 1'b0;
        #50 scl = 1'b1;
        #50 sda_m = 1'b1;
        #50;
    endtask
    // data set mid low phase, sampled mid high phase
    task bus_bit(input reg b, output reg r);
        #50 sda_m = b;
        #50 scl = 1'b1;
        #50 r = sda;
        #50 scl = 1'b0;
    endtask
    task put_byte(input reg [7:0] d, output reg ack);
        integer i;
        reg r;
        for (i = 7; i >= 0; i = i - 1)
            bus_bit(d[i], r);
        bus_bit(1'b1, r);
        ack = ~r;
    endtask
    task get_byte(input reg last, output reg [7:0] d);
        integer i;
        reg r;
        for (i = 7; i >= 0; i = i - 1) begin
            bus_bit(1'b1, r);
            d[i] = r;
            // long low after the first bit: a command conversion ends before its alert bit
            if (i == 7)
                #400;
        end
        bus_bit(last, r);
    endtask
endmodule // aic_i2c_master

/* File: sim/tb.sv */
// self-checking bench for the adc i2c control block
`timescale 1ns/1ps
`include "aic_map.vh"
module tb;
    reg sys_clk = 1'b0;
    reg nrst = 1'b0;
    reg start_n = 1'b1;
    reg [1:0] strap_lo = 2'h0;
    reg [1:0] strap_hi = 2'h0;
    reg [11:0] samp [0:3];
    wire scl, sda_m, sda_out, sda_oe_n, adc_hold, adc_power_down, conv_busy;
    wire [1:0] adc_channel;
    wire sda = sda_m & (sda_oe_n | sda_out);
    integer seed = 80;
    integer fails = 0;
    integer check_count = 0;
    integer i, j, k, ch;
    reg [6:0] dev;
    reg [15:0] v;
    reg [3:0] mask;
    reg ack;
    always #12.5 sys_clk = ~sys_clk;
    aic_i2c_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
    aic_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conversion_start_pin_n(start_n),
        .address_strap_low(strap_lo), .address_strap_high(strap_hi),
        .adc_sample_data(samp[adc_channel]), .adc_alert(^samp[adc_channel]),
        .adc_hold(adc_hold), .adc_channel(adc_channel), .adc_power_down(adc_power_down),
        .conv_busy(conv_busy));
    function [1:0] enc(input [1:0] code);
        enc = (code == 2'h1) ? 2'h0 : (code == 2'h0) ? 2'h3 : 2'h2;
    endfunction
    function [15:0] ew(input integer c);
        ew = {1'b0, c[1:0], ^samp[c], samp[c]};
    endfunction
    function integer nxt(input [3:0] msk, input integer c);
        integer n;
        nxt = 0;
        for (n = 4; n >= 1; n = n - 1)
            if (msk[(c + n) % 4])
                nxt = (c + n) % 4;
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wopen(input [7:0] a, input reg eack);
        @(posedge sys_clk) #1;
        m.bus_start;
        m.put_byte(a, ack);
        chk({15'h0, ack}, {15'h0, eack});
    endtask
    task wpart(input [7:0] p, input integer n, input [15:0] d);
        m.put_byte(p, ack);
        chk({15'h0, ack}, 16'h0001);
        if (n == 2)
            m.put_byte(d[15:8], ack);
        if (n == 2)
            chk({15'h0, ack}, 16'h0001);
        if (n > 0)
            m.put_byte(d[7:0], ack);
        if (n > 0)
            chk({15'h0, ack}, 16'h0001);
    endtask
    task rdw(input reg last, input [15:0] e);
        reg [7:0] hi, lo;
        m.get_byte(1'b0, hi);
        m.get_byte(last, lo);
        chk({hi, lo}, e);
    endtask
    task rdreg(input [7:0] p, input [15:0] e);
        wopen({dev, 1'b0}, 1'b1);
        wpart(p, 0, 16'h0000);
        m.bus_stop;
        wopen({dev, 1'b1}, 1'b1);
        rdw(1'b1, e);
        m.bus_stop;
    endtask
    task hold_wait(input reg lvl);
        for (i = 0; i < 400 && adc_hold !== lvl; i = i + 1)
            @(posedge sys_clk) #1;
        if (adc_hold !== lvl) begin
            fails = fails + 1;
            $display("[FAIL] %0t conversion wait timed out", $time);
            complete_run;
        end
    endtask
    task cmd_reads(input integer n);
        wopen({dev, 1'b1}, 1'b1);
        for (k = 0; k < n; k = k + 1) begin
            ch = nxt(mask, ch);
            rdw(k == n - 1, ew(ch));
        end
        m.bus_stop;
    endtask
    initial begin
        for (j = 0; j < 4; j = j + 1)
            samp[j] = $random(seed);
        strap_lo = $unsigned($random(seed)) % 3;
        strap_hi = $unsigned($random(seed)) % 3;
        dev = {3'b010, enc(strap_hi), enc(strap_lo)};
        repeat (10) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (10) @(posedge sys_clk);
        rdreg(`AIC_REG_CHAN, {8'h00, `AIC_CHAN_RST});
        wopen({dev, 1'b1}, 1'b1);
        rdw(1'b0, {8'h00, `AIC_CHAN_RST});
        rdw(1'b1, {8'h00, `AIC_CHAN_RST});
        m.bus_stop;
        rdreg(`AIC_REG_CFG, `AIC_CFG_RST);
        wopen({dev ^ 7'h01, 1'b0}, 1'b0);
        m.bus_stop;
        $display("test reset and addressing done");
        v = $random(seed) & 16'hFCFF;
        mask = v[15:12] | 4'h1;
        wopen({dev, 1'b0}, 1'b1);
        wpart(`AIC_REG_CFG, 2, v);
        wpart(`AIC_REG_CHAN, 1, {12'h000, mask});
        m.bus_stop;
        rdreg(`AIC_REG_CFG, v);
        rdreg(`AIC_REG_CHAN, {12'h000, mask});
        $display("test register writes done");
        for (j = 0; j < 2; j = j + 1) begin
            wopen({dev, 1'b0}, 1'b1);
            wpart(`AIC_REG_CFG, 2, j ? 16'h0300 : v);
            wpart(`AIC_REG_CHAN, 1, {12'h000, mask});
            wpart(`AIC_REG_RESULT, 2, $random(seed));
            m.bus_stop;
            ch = 3;
            for (k = 0; k < 5; k = k + 1) begin
                @(posedge sys_clk) #1 start_n = 1'b0;
                repeat (8) @(posedge sys_clk);
                #1 start_n = 1'b1;
                hold_wait(1'b1);
                hold_wait(1'b0);
                repeat (4) @(posedge sys_clk);
                ch = nxt(mask, ch);
                wopen({dev, 1'b1}, 1'b1);
                rdw(1'b1, ew(ch));
                m.bus_stop;
            end
            chk({15'h0, adc_power_down}, 16'h0000);
        end
        $display("test sample mode done");
        wopen({dev, 1'b0}, 1'b1);
        wpart(`AIC_REG_CFG, 2, 16'h0200);
        wpart(`AIC_REG_CHAN, 1, 16'h0007);
        wpart(`AIC_REG_RESULT, 0, 16'h0000);
        m.bus_stop;
        mask = 4'h7;
        ch = 3;
        cmd_reads(4);
        chk({15'h0, adc_power_down}, 16'h0001);
        cmd_reads(2);
        wopen({dev, 1'b0}, 1'b1);
        wpart(`AIC_REG_CHAN, 1, 16'h000C);
        wpart(`AIC_REG_RESULT, 0, 16'h0000);
        m.bus_stop;
        mask = 4'hC;
        ch = 3;
        cmd_reads(3);
        $display("test command mode done");
        complete_run;
    end
endmodule // tb
